/* File: dacs_params.svh */
// Constants for the dual converter conversion sequencer
`ifndef DACS_PARAMS_SVH
`define DACS_PARAMS_SVH

`define DACS_NUM_CONV 2
`define DACS_NUM_CHAN 16
`define DACS_NUM_PAIR 8
`define DACS_NUM_EXT_TRIG 8
`define DACS_NUM_EOC 8
`define DACS_RES_W 12
`define DACS_CTL_W 13
`define DACS_WIN_LSB 0
`define DACS_WIN_W 6
`define DACS_TRIG_LSB 6
`define DACS_TRIG_W 3
`define DACS_INSEL_LSB 9
`define DACS_INSEL_W 4
`define DACS_WIN_MIN_CLK 7
`define DACS_WIN_MAX_CLK 64
`define DACS_WIN_MIN_LIM 6'h06
`define DACS_ITS_EXT 2'h0
`define DACS_ITS_INT1 2'h1
`define DACS_ITS_INT2 2'h2
`define DACS_MUX_A_LAST 3'h5
`define DACS_MUX_B_LAST 3'h6
`define DACS_LOW_REF_SEL 3'h6
`define DACS_MAP_W 5
`define DACS_MAP_EN_BIT 4
`define DACS_PRIO_W 5
`define DACS_REG_CHAN_CTL 3'h0
`define DACS_REG_PAIRING 3'h1
`define DACS_REG_ITS_LO 3'h2
`define DACS_REG_ITS_HI 3'h3
`define DACS_REG_PRIO 3'h4
`define DACS_REG_EOC_MAP 3'h5
`define DACS_CTL_RST 13'h0000
`define DACS_PAIRING_RST 8'h00
`define DACS_PRIO_RST 5'h00

`endif

/* File: dacs_pkg.sv */
// Types for the dual converter conversion sequencer
`include "dacs_params.svh"
package dacs_pkg;
	typedef enum logic [2:0] {
		DACS_IDLE,
		DACS_SAMPLE,
		DACS_CONV_FIRST,
		DACS_CONV_SECOND
	} dacs_phase_t;

	typedef struct packed {
		dacs_phase_t phase;
		logic [`DACS_NUM_CHAN-1:0][`DACS_CTL_W-1:0] chan_ctl;
		logic [`DACS_NUM_PAIR-1:0] pairing;
		logic [`DACS_NUM_CHAN-1:0][1:0] its;
		logic [`DACS_PRIO_W-1:0] prio;
		logic [`DACS_NUM_EOC-1:0][`DACS_MAP_W-1:0] eoc_map;
		logic [`DACS_NUM_CHAN-1:0][`DACS_RES_W-1:0] result;
		logic [`DACS_NUM_CHAN-1:0] pending;
		logic [`DACS_NUM_CHAN-1:0] written;
		logic [`DACS_NUM_EXT_TRIG-1:0] ext_prev;
		logic [3:0] cur_chan;
		logic cur_simul;
		logic cur_group;
		logic [`DACS_WIN_W-1:0] win_cnt;
		logic [`DACS_WIN_W-1:0] win_lim;
		logic [3:0] rr_last;
		logic [2:0] mux_a;
		logic [2:0] mux_b;
		logic sh_a;
		logic sh_b;
		logic conv_start;
		logic conv_group;
		logic [`DACS_NUM_EOC-1:0] eoc_flag;
		logic [`DACS_NUM_EOC-1:0] eoc_pulse;
	} dacs_conv_t;

	typedef struct packed {
		logic [`DACS_RES_W-1:0] rd_data;
		logic rd_valid;
		logic cfg_denied;
		logic [`DACS_NUM_EOC-1:0] eoc_master;
		logic [`DACS_NUM_EOC-1:0] eoc_control;
	} dacs_top_t;
endpackage : dacs_pkg

/* File: dacs_arbiter.sv */
// Picks the next pending channel: fixed priority block, then round robin
`timescale 1ns/1ns
`default_nettype none
module dacs_arbiter
	import dacs_pkg::*;
(
	// Requests and priority setting
	input wire logic [15:0] request_in,
	input wire logic [4:0] prio_in,
	input wire logic [3:0] rr_last_in,
	// Grant
	output logic grant_valid_out,
	output logic [3:0] grant_idx_out
);
	logic [3:0] idx;

	always_comb begin
		grant_valid_out = 1'b0;
		grant_idx_out = 4'h0;
		idx = 4'h0;
		// Round robin among channels above the fixed block, next after last served
		for (int k = 16; k >= 1; k--) begin
			idx = rr_last_in + 4'(k);
			if (request_in[idx] && ({1'b0, idx} >= prio_in)) begin
				grant_valid_out = 1'b1;
				grant_idx_out = idx;
			end
		end
		// Fixed block always beats round robin; lowest index first
		for (int i = 15; i >= 0; i--) begin
			if (request_in[i] && (5'(i) < prio_in)) begin
				grant_valid_out = 1'b1;
				grant_idx_out = 4'(i);
			end
		end
	end
endmodule : dacs_arbiter
`default_nettype wire

/* File: dacs_sequencer.sv */
// Dual converter conversion sequencer: triggers, arbitration, sampling, results, EOC
`include "dacs_params.svh"
`timescale 1ns/1ns
`default_nettype none
module dacs_sequencer
	import dacs_pkg::*;
#(
	parameter int CHANNELS = 16,
	parameter int EOC_LINES = 8
)
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Configuration write port
	input wire logic cfg_wr_in,
	input wire logic cfg_from_control_in,
	input wire logic cfg_conv_in,
	input wire logic [2:0] cfg_reg_in,
	input wire logic [3:0] cfg_index_in,
	input wire logic [15:0] cfg_data_in,
	output logic cfg_denied_out,
	// Result read port, open to every requester
	input wire logic rd_en_in,
	input wire logic rd_conv_in,
	input wire logic [3:0] rd_index_in,
	output logic [11:0] rd_data_out,
	output logic rd_valid_out,
	// Start-of-conversion triggers from the control subsystem
	input wire logic [7:0] ext_trig_in,
	// EOC interrupt acknowledge, one mask per converter
	input wire logic [1:0][7:0] eoc_ack_in,
	// Analog core handshake per converter
	input wire logic [1:0] conv_done_in,
	input wire logic [1:0][11:0] conv_data_in,
	output logic [1:0] conv_start_out,
	output logic [1:0] conv_group_out,
	output logic [1:0][2:0] mux_a_sel_out,
	output logic [1:0][2:0] mux_b_sel_out,
	output logic [1:0] sh_a_sample_out,
	output logic [1:0] sh_b_sample_out,
	// Status
	output logic [1:0] busy_out,
	output logic [1:0][7:0] eoc_flag_out,
	output logic [7:0] eoc_master_out,
	output logic [7:0] eoc_control_out
);
	// Refused at elaboration: the decode below is sized for the documented counts only
	if (CHANNELS != `DACS_NUM_CHAN || EOC_LINES != `DACS_NUM_EOC) begin : gen_bad_cfg
		$error("dacs_sequencer: only 16 channels and 8 EOC lines are supported");
	end

	// Clamp a mux code to the last valid input of its group
	function automatic logic [2:0] dacs_clamp_sel(input logic [2:0] v, input logic [2:0] last);
		dacs_clamp_sel = (v > last) ? last : v;
	endfunction : dacs_clamp_sel

	// Window field holds clocks minus one; below the minimum it is raised to it
	function automatic logic [5:0] dacs_win_lim(input logic [12:0] ctl);
		logic [5:0] w;
		w = ctl[`DACS_WIN_LSB +: `DACS_WIN_W];
		dacs_win_lim = (w < `DACS_WIN_MIN_LIM) ? `DACS_WIN_MIN_LIM : w;
	endfunction : dacs_win_lim

	logic [1:0][15:0][11:0] res_w;
	logic [1:0][7:0] flag_w;

	genvar g;
	generate
		for (g = 0; g < `DACS_NUM_CONV; g++) begin : gen_conv
			dacs_conv_t s;
			dacs_conv_t next_s;
			logic [15:0] req;
			logic grant_valid;
			logic [3:0] grant_idx;
			logic [7:0] ext_rise;
			logic [12:0] ctl;
			logic [2:0] insel;
			logic [3:0] even_chan;
			logic cfg_hit;

			// Odd channel of a simultaneous pair never requests
			always_comb begin
				for (int c = 0; c < 16; c++) begin
					req[c] = s.pending[c] && !((c % 2 == 1) && s.pairing[c/2]);
				end
			end

			dacs_arbiter u_arb (
				.request_in(req),
				.prio_in(s.prio),
				.rr_last_in(s.rr_last),
				.grant_valid_out(grant_valid),
				.grant_idx_out(grant_idx)
			);

			always_comb begin
				next_s = s;
				ctl = s.chan_ctl[grant_idx];
				insel = ctl[`DACS_INSEL_LSB +: 3];
				even_chan = {s.cur_chan[3:1], 1'b0};
				ext_rise = ext_trig_in & ~s.ext_prev;
				cfg_hit = cfg_wr_in && cfg_from_control_in && (cfg_conv_in == 1'(g));
				next_s.conv_start = 1'b0;
				next_s.written = '0;
				next_s.eoc_pulse = '0;
				next_s.ext_prev = ext_trig_in;

				if (cfg_hit) begin
					case (cfg_reg_in)
						`DACS_REG_CHAN_CTL: begin
							next_s.chan_ctl[cfg_index_in] = cfg_data_in[12:0];
						end
						`DACS_REG_PAIRING: begin
							next_s.pairing = cfg_data_in[7:0];
						end
						`DACS_REG_ITS_LO: begin
							for (int c = 0; c < 8; c++) begin
								next_s.its[c] = cfg_data_in[2*c +: 2];
							end
						end
						`DACS_REG_ITS_HI: begin
							for (int c = 0; c < 8; c++) begin
								next_s.its[c+8] = cfg_data_in[2*c +: 2];
							end
						end
						`DACS_REG_PRIO: begin
							next_s.prio = cfg_data_in[4:0];
						end
						`DACS_REG_EOC_MAP: begin
							next_s.eoc_map[cfg_index_in[2:0]] = cfg_data_in[4:0];
						end
						default: begin
						end
					endcase
				end

				case (s.phase)
					DACS_IDLE: begin
						if (grant_valid) begin
							next_s.pending[grant_idx] = 1'b0;
							next_s.cur_chan = grant_idx;
							next_s.cur_simul = s.pairing[grant_idx[3:1]];
							next_s.cur_group = ctl[`DACS_INSEL_LSB + 3];
							next_s.rr_last = grant_idx;
							next_s.win_cnt = '0;
							next_s.win_lim = dacs_win_lim(ctl);
							next_s.phase = DACS_SAMPLE;
							if (s.pairing[grant_idx[3:1]]) begin
								// Both S/H units sample the paired inputs together
								next_s.mux_a = dacs_clamp_sel(insel, `DACS_MUX_A_LAST);
								next_s.mux_b = dacs_clamp_sel(insel, `DACS_MUX_A_LAST);
								next_s.sh_a = 1'b1;
								next_s.sh_b = 1'b1;
							end else if (ctl[`DACS_INSEL_LSB + 3]) begin
								next_s.mux_b = dacs_clamp_sel(insel, `DACS_MUX_B_LAST);
								next_s.sh_b = 1'b1;
							end else begin
								next_s.mux_a = dacs_clamp_sel(insel, `DACS_MUX_A_LAST);
								next_s.sh_a = 1'b1;
							end
						end
					end
					DACS_SAMPLE: begin
						next_s.win_cnt = s.win_cnt + 6'h01;
						if (s.win_cnt == s.win_lim) begin
							next_s.sh_a = 1'b0;
							next_s.sh_b = 1'b0;
							next_s.conv_start = 1'b1;
							next_s.conv_group = s.cur_simul ? 1'b0 : s.cur_group;
							next_s.phase = DACS_CONV_FIRST;
						end
					end
					DACS_CONV_FIRST: begin
						if (conv_done_in[g]) begin
							if (s.cur_simul) begin
								next_s.result[even_chan] = conv_data_in[g];
								next_s.written[even_chan] = 1'b1;
								// Single converter: second held sample follows at once
								next_s.conv_start = 1'b1;
								next_s.conv_group = 1'b1;
								next_s.phase = DACS_CONV_SECOND;
							end else begin
								next_s.result[s.cur_chan] = conv_data_in[g];
								next_s.written[s.cur_chan] = 1'b1;
								next_s.phase = DACS_IDLE;
							end
						end
					end
					DACS_CONV_SECOND: begin
						if (conv_done_in[g]) begin
							next_s.result[{s.cur_chan[3:1], 1'b1}] = conv_data_in[g];
							next_s.written[{s.cur_chan[3:1], 1'b1}] = 1'b1;
							next_s.phase = DACS_IDLE;
						end
					end
					default: begin
						next_s.phase = DACS_IDLE;
					end
				endcase

				// Flags follow the stored result by one cycle; set wins over acknowledge
				for (int e = 0; e < 8; e++) begin
					if (eoc_ack_in[g][e]) begin
						next_s.eoc_flag[e] = 1'b0;
					end
					if (s.eoc_map[e][`DACS_MAP_EN_BIT] && s.written[s.eoc_map[e][3:0]]) begin
						next_s.eoc_flag[e] = 1'b1;
						next_s.eoc_pulse[e] = 1'b1;
					end
				end

				// Triggers after the grant so a new trigger is not lost to the clear
				for (int c = 0; c < 16; c++) begin
					if (!((c % 2 == 1) && s.pairing[c/2])) begin
						case (s.its[c])
							`DACS_ITS_EXT: begin
								if (ext_rise[s.chan_ctl[c][`DACS_TRIG_LSB +: `DACS_TRIG_W]]) begin
									next_s.pending[c] = 1'b1;
								end
							end
							`DACS_ITS_INT1: begin
								if (s.eoc_pulse[0]) begin
									next_s.pending[c] = 1'b1;
								end
							end
							`DACS_ITS_INT2: begin
								if (s.eoc_pulse[1]) begin
									next_s.pending[c] = 1'b1;
								end
							end
							default: begin
							end
						endcase
					end
				end
			end

			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					s <= '0;
				end else begin
					s <= next_s;
				end
			end

			assign res_w[g] = s.result;
			assign flag_w[g] = s.eoc_flag;
			assign conv_start_out[g] = s.conv_start;
			assign conv_group_out[g] = s.conv_group;
			assign mux_a_sel_out[g] = s.mux_a;
			assign mux_b_sel_out[g] = s.mux_b;
			assign sh_a_sample_out[g] = s.sh_a;
			assign sh_b_sample_out[g] = s.sh_b;
			assign busy_out[g] = (s.phase != DACS_IDLE);
			assign eoc_flag_out[g] = s.eoc_flag;
		end
	endgenerate

	dacs_top_t t;
	dacs_top_t next_t;

	always_comb begin
		next_t = t;
		next_t.rd_valid = rd_en_in;
		if (rd_en_in) begin
			next_t.rd_data = res_w[rd_conv_in][rd_index_in];
		end
		next_t.cfg_denied = cfg_wr_in && !cfg_from_control_in;
		// Both converters' lines are ANDed, as the shared interrupt fabric does
		next_t.eoc_master = flag_w[0] & flag_w[1];
		next_t.eoc_control = flag_w[0] & flag_w[1];
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			t <= '0;
		end else begin
			t <= next_t;
		end
	end

	assign rd_data_out = t.rd_data;
	assign rd_valid_out = t.rd_valid;
	assign cfg_denied_out = t.cfg_denied;
	assign eoc_master_out = t.eoc_master;
	assign eoc_control_out = t.eoc_control;
endmodule : dacs_sequencer
`default_nettype wire

/* File: dacs_sequencer_checker.sv */
// Port-level assertions for the dual converter sequencer
`timescale 1ns/1ns
`default_nettype none
module dacs_sequencer_checker
	import dacs_pkg::*;
#(
	parameter int CHANNELS = 16,
	parameter int EOC_LINES = 8
)
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Config and read
	input wire logic cfg_wr_in,
	input wire logic cfg_from_control_in,
	input wire logic cfg_denied_out,
	input wire logic rd_en_in,
	input wire logic rd_valid_out,
	// Converter side
	input wire logic [1:0] conv_start_out,
	input wire logic [1:0] busy_out,
	input wire logic [1:0][2:0] mux_a_sel_out,
	input wire logic [1:0][2:0] mux_b_sel_out,
	input wire logic [1:0] sh_a_sample_out,
	input wire logic [1:0] sh_b_sample_out,
	// Interrupts
	input wire logic [1:0][7:0] eoc_flag_out,
	input wire logic [7:0] eoc_master_out,
	input wire logic [7:0] eoc_control_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	property p_deny; cfg_wr_in && !cfg_from_control_in |=> cfg_denied_out; endproperty
	a_deny: assert property (p_deny) else $error("refused write not flagged");
	property p_allow; !(cfg_wr_in && !cfg_from_control_in) |=> !cfg_denied_out; endproperty
	a_allow: assert property (p_allow) else $error("spurious denial");
	property p_read; rd_en_in |=> rd_valid_out; endproperty
	a_read: assert property (p_read) else $error("read not answered");
	property p_start; conv_start_out[0] |-> busy_out[0] ##1 !conv_start_out[0]; endproperty
	a_start: assert property (p_start) else $error("start pulse wrong");
	property p_win; $rose(sh_a_sample_out[0]) |-> sh_a_sample_out[0] [*7]; endproperty
	a_win: assert property (p_win) else $error("sample window short");
	property p_go; $fell(sh_a_sample_out[1] | sh_b_sample_out[1]) |-> conv_start_out[1]; endproperty
	a_go: assert property (p_go) else $error("no start after sampling");
	property p_mux;
		mux_a_sel_out[0] <= 3'h5 && mux_a_sel_out[1] <= 3'h5 &&
			mux_b_sel_out[0] <= 3'h6 && mux_b_sel_out[1] <= 3'h6;
	endproperty
	a_mux: assert property (p_mux) else $error("mux code out of range");
	property p_and;
		eoc_master_out == $past(eoc_flag_out[0] & eoc_flag_out[1]) &&
			eoc_control_out == eoc_master_out;
	endproperty
	a_and: assert property (p_and) else $error("combined interrupt wrong");
	c_pair: cover property (sh_a_sample_out[1] && sh_b_sample_out[1]);
	c_deny: cover property (cfg_denied_out);
	c_and: cover property (eoc_master_out != 8'h00);
endmodule : dacs_sequencer_checker

bind dacs_sequencer dacs_sequencer_checker #(.CHANNELS(CHANNELS), .EOC_LINES(EOC_LINES)) u_chk (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_wr_in(cfg_wr_in),
	.cfg_from_control_in(cfg_from_control_in), .cfg_denied_out(cfg_denied_out),
	.rd_en_in(rd_en_in), .rd_valid_out(rd_valid_out), .conv_start_out(conv_start_out),
	.busy_out(busy_out), .mux_a_sel_out(mux_a_sel_out), .mux_b_sel_out(mux_b_sel_out),
	.sh_a_sample_out(sh_a_sample_out), .sh_b_sample_out(sh_b_sample_out),
	.eoc_flag_out(eoc_flag_out), .eoc_master_out(eoc_master_out),
	.eoc_control_out(eoc_control_out)
);
`default_nettype wire

/* File: dacs_analog_model.sv */
// Behavioural analog core: each start pulse gets a done pulse with tagged data
`timescale 1ns/1ns
`default_nettype none
module dacs_analog_model
	import dacs_pkg::*;
(
	// Clock and pacing
	input wire logic clk_in,
	input wire logic slow_in,
	// Sequencer side
	input wire logic [1:0] conv_start_in,
	input wire logic [1:0] conv_group_in,
	input wire logic [1:0][2:0] mux_a_sel_in,
	input wire logic [1:0][2:0] mux_b_sel_in,
	output logic [1:0] conv_done_out,
	output logic [1:0][11:0] conv_data_out
);
	int cnt [2] = '{0, 0};
	logic [1:0][11:0] hold;
	initial begin
		conv_done_out = 2'h0;
		conv_data_out = 24'h5A5A5A;
	end
	// Data toggles while invalid so a late capture never matches by luck
	always @(posedge clk_in) begin
		for (int c = 0; c < 2; c++) begin
			conv_done_out[c] <= 1'b0;
			conv_data_out[c] <= ~conv_data_out[c];
			if (conv_start_in[c] === 1'b1) begin
				cnt[c] <= slow_in ? 9 : 1;
				hold[c] <= {4'hA, c[0], conv_group_in[c], 3'h0,
					conv_group_in[c] ? mux_b_sel_in[c] : mux_a_sel_in[c]};
			end else if (cnt[c] == 1) begin
				conv_done_out[c] <= 1'b1;
				conv_data_out[c] <= hold[c];
				cnt[c] <= 0;
			end else if (cnt[c] > 1) begin
				cnt[c] <= cnt[c] - 1;
			end
		end
	end
endmodule : dacs_analog_model
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the dual converter sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb
	import dacs_pkg::*;
;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic cfg_wr_in = 1'b0;
	logic cfg_from_control_in = 1'b1;
	logic cfg_conv_in = 1'b0;
	logic [2:0] cfg_reg_in = 3'h0;
	logic [3:0] cfg_index_in = 4'h0;
	logic [15:0] cfg_data_in = 16'h0000;
	logic rd_en_in = 1'b0;
	logic rd_conv_in = 1'b0;
	logic [3:0] rd_index_in = 4'h0;
	logic [7:0] ext_trig_in = 8'h00;
	logic [1:0][7:0] eoc_ack_in = 16'h0000;
	logic slow = 1'b0;
	logic cfg_denied_out, rd_valid_out;
	logic [11:0] rd_data_out;
	logic [1:0] conv_done_in, conv_start_out, conv_group_out, busy_out;
	logic [1:0] sh_a_sample_out, sh_b_sample_out;
	logic [1:0][11:0] conv_data_in;
	logic [1:0][2:0] mux_a_sel_out, mux_b_sel_out;
	logic [1:0][7:0] eoc_flag_out;
	logic [7:0] eoc_master_out, eoc_control_out;
	logic [31:0] seed = 32'h0000F7A5;
	int n_errors = 0;
	int n_checks = 0;
	int shn = 0;
	int exp_res [2][16];
	dacs_sequencer u_dut (.*);
	dacs_analog_model u_ana (
		.clk_in(clk_in), .slow_in(slow), .conv_start_in(conv_start_out),
		.conv_group_in(conv_group_out), .mux_a_sel_in(mux_a_sel_out),
		.mux_b_sel_in(mux_b_sel_out), .conv_done_out(conv_done_in), .conv_data_out(conv_data_in)
	);
	always #25 clk_in = ~clk_in;
	// Sampling cycles seen on either hold unit
	always @(posedge clk_in)
		shn <= shn + int'((sh_a_sample_out | sh_b_sample_out) != 2'h0);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic int exp_data(int c, int g, int code);
		return 'hA00 + c * 128 + g * 64 + code;
	endfunction : exp_data
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict
	task automatic tick(int n);
		repeat (n) @(posedge clk_in);
		#2;
	endtask : tick
	// Strobe stays up between back-to-back writes; fire lowers it, chk_res does not
	task automatic wr(logic c, logic [2:0] r, logic [3:0] i, logic [15:0] d);
		rd_en_in = 1'b0;
		cfg_wr_in = 1'b1;
		cfg_conv_in = c;
		cfg_reg_in = r;
		cfg_index_in = i;
		cfg_data_in = d;
		tick(1);
	endtask : wr
	// Reads have no side effect, so the strobe may stay up until another task runs
	task automatic chk_res(logic c, logic [3:0] i);
		rd_en_in = 1'b1;
		rd_conv_in = c;
		rd_index_in = i;
		tick(1);
		`CHK(rd_valid_out, 1'b1)
		`CHK(rd_data_out, exp_res[c][i][11:0])
	endtask : chk_res
	// Waits for the given number of busy spans, as internal triggers chain conversions
	task automatic fire(logic [2:0] t, int spans);
		int k;
		shn = 0;
		cfg_wr_in = 1'b0;
		rd_en_in = 1'b0;
		ext_trig_in[t] = 1'b1;
		tick(1);
		ext_trig_in[t] = 1'b0;
		tick(2);
		repeat (spans) begin
			for (k = 0; k < 400 && busy_out !== 2'h0; k++)
				tick(1);
			if (k == 400) begin
				n_errors++;
				give_verdict();
			end
			tick(6);
		end
	endtask : fire
	initial begin
		logic [31:0] r;
		logic c;
		logic [3:0] ch, sel;
		logic [2:0] t, code;
		logic [5:0] w;
		foreach (exp_res[i, j])
			exp_res[i][j] = 0;
		tick(6);
		rst_n_in = 1'b1;
		`CHK({busy_out, eoc_flag_out, cfg_denied_out, rd_valid_out}, 20'h00000)
		for (int i = 0; i < 4; i++)
			wr(i[0], {2'h1, i[1]}, 4'h0, 16'hFFFF);
		cfg_from_control_in = 1'b0;
		wr(1'b0, 3'h2, 4'h0, 16'h0000);
		cfg_wr_in = 1'b0;
		`CHK(cfg_denied_out, 1'b1)
		cfg_from_control_in = 1'b1;
		fire(3'h0, 1);
		chk_res(1'b0, 4'h0);
		$display("test denial done");
		for (int n = 0; n < 12; n++) begin
			r = rnd();
			c = r[0];
			ch = r[4:1];
			t = r[7:5];
			sel = r[11:8];
			w = 6'(6 + r[17:12] % 58);
			slow = r[18];
			wr(c, 3'h0, ch, {3'h0, sel, t, w});
			wr(c, {2'h1, ch[3]}, 4'h0, ~(16'h0003 << {ch[2:0], 1'b0}));
			wr(c, 3'h5, {1'b0, ch[2:0]}, {11'h000, 1'b1, ch});
			fire(t, 1);
			`CHK(shn, w + 1)
			code = sel[3] ? (sel[2:0] > 3'h6 ? 3'h6 : sel[2:0]) : (sel[2:0] > 3'h5 ? 3'h5 : sel[2:0]);
			exp_res[c][ch] = exp_data(c, sel[3], code);
			chk_res(c, ch);
			`CHK(eoc_flag_out[c][ch[2:0]], 1'b1)
			eoc_ack_in = 16'hFFFF;
			tick(1);
			eoc_ack_in = 16'h0000;
			`CHK(eoc_flag_out, 16'h0000)
			wr(c, {2'h1, ch[3]}, 4'h0, 16'hFFFF);
		end
		$display("test sequential done");
		wr(1'b1, 3'h1, 4'h0, 16'h0004);
		wr(1'b1, 3'h2, 4'h0, 16'hF0FF);
		wr(1'b1, 3'h5, 4'h0, 16'h0015);
		wr(1'b1, 3'h0, 4'h5, {3'h0, 4'h2, 3'h3, 6'h06});
		wr(1'b1, 3'h0, 4'h4, {3'h0, 4'h7, 3'h1, 6'h10});
		fire(3'h3, 1);
		`CHK(shn, 0)
		fire(3'h1, 1);
		`CHK(shn, 17)
		exp_res[1][4] = exp_data(1, 0, 5);
		exp_res[1][5] = exp_data(1, 1, 5);
		chk_res(1'b1, 4'h4);
		chk_res(1'b1, 4'h5);
		$display("test pair done");
		wr(1'b0, 3'h0, 4'h2, 16'h0686);
		wr(1'b0, 3'h0, 4'h9, 16'h1206);
		wr(1'b0, 3'h0, 4'hA, 16'h0C06);
		wr(1'b0, 3'h5, 4'h0, 16'h0012);
		wr(1'b0, 3'h5, 4'h1, 16'h0019);
		wr(1'b0, 3'h2, 4'h0, 16'hFFCF);
		wr(1'b0, 3'h3, 4'h0, 16'hFFE7);
		fire(3'h2, 3);
		exp_res[0][2] = exp_data(0, 0, 3);
		exp_res[0][9] = exp_data(0, 1, 1);
		exp_res[0][10] = exp_data(0, 0, 5);
		chk_res(1'b0, 4'h2);
		chk_res(1'b0, 4'h9);
		chk_res(1'b0, 4'hA);
		`CHK(eoc_master_out[0], 1'b1)
		eoc_ack_in = 16'hFFFF;
		tick(2);
		eoc_ack_in = 16'h0000;
		`CHK(eoc_control_out, 8'h00)
		$display("test internal trigger done");
		give_verdict();
	end
endmodule : tb
`default_nettype wire
